/* design/l2ctl_pkg.sv */
/*
  l2ctl_pkg: register offsets, field positions, reset values and modes of
  the l2 cache general control block.
  Assumes: a 32-bit apb register bus, one clock domain.
*/
package l2ctl_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] GEN_CTRL_OFFSET  = 12'h000;
  localparam logic [11:0] CACHE_STAT_OFFSET = 12'h020;
  localparam int          REG_WIDTH        = 16;

  // ----------------------------------------------------------------------
  // general control fields
  // ----------------------------------------------------------------------
  localparam int BADAP_BIT   = 13;
  localparam int FRCP_BIT    = 12;
  localparam int FRCV_BIT    = 11;
  localparam int FRCD_BIT    = 10;
  localparam int FRCTAG_BIT  = 9;
  localparam int IGNTAG_BIT  = 8;
  localparam int LONGWR_BIT  = 7;
  localparam int NOALLOC_BIT = 6;
  localparam int EN_BIT      = 5;
  localparam int WIDE_BIT    = 4;
  localparam int ARB_LO_BIT  = 1;

  localparam logic [15:0] GEN_CTRL_RESET = 16'h0000;
  localparam logic [15:0] GEN_CTRL_WMASK = 16'h3FE6;

  // ----------------------------------------------------------------------
  // arbitration modes
  // ----------------------------------------------------------------------
  localparam logic [1:0] ARB_DMA        = 2'h2;
  localparam logic [1:0] ARB_DMA_STRONG = 2'h3;

  // data ram write hold in bus cycles
  localparam logic [1:0] WR_CYCLES_SHORT = 2'h1;
  localparam logic [1:0] WR_CYCLES_LONG  = 2'h2;

  typedef enum logic [1:0] {
    GRANT_NONE,
    GRANT_CPU,
    GRANT_DMA
  } grant_t;

endpackage

/* design/l2_cache_req_if.sv */
/*
  l2_cache_req_if: probe and fill signals passed between the control top and
  the cache sequencer.
  Assumes: single clock, driven only inside the design.
*/
`timescale 1ns/1ps
`default_nettype none
interface l2_cache_req_if;
  logic       probe;
  logic       hit_tag;
  logic       tag_par_ok;
  logic       line_valid;
  logic       line_dirty;
  logic       cpu_write;
  logic       data_wr;
  logic       probe_q;
  logic       miss;
  logic       victim_wb;
  logic       fill;
  logic       fill_valid;
  logic       fill_dirty;
  logic       fill_par;
  logic       fill_bad_ap;
  logic       data_we;
  modport ctrl (output probe, hit_tag, tag_par_ok, line_valid, line_dirty, cpu_write,
                data_wr, input probe_q, miss, victim_wb, fill, fill_valid, fill_dirty,
                fill_par, fill_bad_ap, data_we);
  modport seq (input probe, hit_tag, tag_par_ok, line_valid, line_dirty, cpu_write,
               data_wr, output probe_q, miss, victim_wb, fill, fill_valid, fill_dirty,
               fill_par, fill_bad_ap, data_we);
endinterface
`default_nettype wire

/* design/l2_cache_seq.sv */
/*
  l2_cache_seq: one-cycle tag probe decision, fill tag controls and data ram
  write hold.
  Assumes: probe requests are single pulses spaced by at least three cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module l2_cache_seq (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // mode bits
  input  wire logic [15:0] ctrl,
  // probe and fill
  l2_cache_req_if.seq      rq
);

  typedef struct packed {
    logic       probe;
    logic       miss;
    logic       victim_wb;
    logic       fill;
    logic       fill_valid;
    logic       fill_dirty;
    logic       fill_par;
    logic       fill_bad_ap;
    logic [1:0] wr_cnt;
  } seq_t;

  seq_t s_q;
  seq_t s_d;

  always_comb begin
    logic en;
    logic ign;
    logic hit;
    en  = ctrl[l2ctl_pkg::EN_BIT];
    ign = ctrl[l2ctl_pkg::IGNTAG_BIT];
    hit = 1'b0;
    s_d = s_q;
    s_d.probe = rq.probe && en; // [RULE_14]
    // ignore tag: every probe misses an invalid line, victims dropped
    if (!ign) begin
      hit = rq.hit_tag && rq.line_valid && rq.tag_par_ok;
    end
    s_d.miss      = s_d.probe && !hit; // [RULE_11]
    s_d.victim_wb = s_d.probe && !hit && !ign && rq.line_valid && rq.line_dirty; // [RULE_11]
    // no allocate on cpu writes
    s_d.fill = s_d.miss && !(rq.cpu_write && ctrl[l2ctl_pkg::NOALLOC_BIT]); // [RULE_13]
    // force tag still fills data; tag controls come from the force bits
    if (ctrl[l2ctl_pkg::FRCTAG_BIT]) begin
      s_d.fill_valid = ctrl[l2ctl_pkg::FRCV_BIT]; // [RULE_09]
      s_d.fill_dirty = ctrl[l2ctl_pkg::FRCD_BIT]; // [RULE_09]
    end else begin
      s_d.fill_valid = 1'b1 | ctrl[l2ctl_pkg::FRCV_BIT]; // [RULE_07]
      s_d.fill_dirty = rq.cpu_write | ctrl[l2ctl_pkg::FRCD_BIT]; // [RULE_08]
    end
    s_d.fill_par    = ctrl[l2ctl_pkg::FRCP_BIT]; // [RULE_06]
    s_d.fill_bad_ap = ctrl[l2ctl_pkg::BADAP_BIT]; // [RULE_05]
    // data ram write held one or two cycles
    if (rq.data_wr && en) begin
      s_d.wr_cnt = ctrl[l2ctl_pkg::LONGWR_BIT] ? l2ctl_pkg::WR_CYCLES_LONG
                                               : l2ctl_pkg::WR_CYCLES_SHORT; // [RULE_12]
    end else if (s_q.wr_cnt != 2'h0) begin
      s_d.wr_cnt = s_q.wr_cnt - 2'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rq.probe_q     = s_q.probe;
  assign rq.miss        = s_q.miss;
  assign rq.victim_wb   = s_q.victim_wb;
  assign rq.fill        = s_q.fill;
  assign rq.fill_valid  = s_q.fill_valid;
  assign rq.fill_dirty  = s_q.fill_dirty;
  assign rq.fill_par    = s_q.fill_par;
  assign rq.fill_bad_ap = s_q.fill_bad_ap;
  assign rq.data_we     = s_q.wr_cnt != 2'h0;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  no_probe_off_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_14]
    !ctrl[l2ctl_pkg::EN_BIT] |=> !s_q.probe)
    else $error("probe while cache disabled");
  ign_miss_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_11]
    rq.probe && ctrl[l2ctl_pkg::EN_BIT] && ctrl[l2ctl_pkg::IGNTAG_BIT]
    |=> s_q.miss && !s_q.victim_wb)
    else $error("ignore tag probe did not miss cleanly");
  long_wr_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_12]
    rq.data_wr && ctrl[l2ctl_pkg::EN_BIT] && ctrl[l2ctl_pkg::LONGWR_BIT]
    |=> rq.data_we [*2])
    else $error("long write not held two cycles");
  // short write: enable seen one edge after the request, gone the edge after
  short_wr_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_12]
    rq.data_wr && ctrl[l2ctl_pkg::EN_BIT] && !ctrl[l2ctl_pkg::LONGWR_BIT]
    ##1 !rq.data_wr |-> rq.data_we ##1 !rq.data_we)
    else $error("short write length wrong");
  no_alloc_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_13]
    rq.cpu_write && ctrl[l2ctl_pkg::NOALLOC_BIT] |=> !s_q.fill)
    else $error("cpu write allocated");
  frc_tag_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_09]
    ctrl[l2ctl_pkg::FRCTAG_BIT] |=> s_q.fill_valid == $past(ctrl[l2ctl_pkg::FRCV_BIT]))
    else $error("force tag valid mismatch");
  bad_ap_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_05]
    ctrl[l2ctl_pkg::BADAP_BIT] |=> s_q.fill_bad_ap)
    else $error("bad address parity not forced");
  frc_par_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_06]
    ctrl[l2ctl_pkg::FRCP_BIT] |=> s_q.fill_par)
    else $error("fill parity not forced");
  fill_cov: cover property (@(posedge clk) disable iff (!reset_n) s_q.fill);
  victim_cov: cover property (@(posedge clk) disable iff (!reset_n) s_q.victim_wb);
  long_cov: cover property (@(posedge clk) disable iff (!reset_n)
    rq.data_we && ctrl[l2ctl_pkg::LONGWR_BIT]);

endmodule
`default_nettype wire

/* design/l2_cache_general_control.sv */
/*
  l2_cache_general_control: apb slave holding the 16-bit general control
  register, cache status register, bus arbiter and the cache sequencer.
  Assumes: apb master per protocol; memory width strap is static.
*/
//
// Function
// RULE_01 - registers are sixteen bits, each on its own line-aligned address
// RULE_02 - reads never change register contents or controller state
// RULE_03 - software writes zero into every unspecified bit
// RULE_04 - only bits 15:0 are defined; upper bus bits read zero, ignored
// RULE_05 - force bad address parity writes wrong tag address parity
// RULE_06 - force parity sets tag control parity on next fill
// RULE_07 - force valid sets valid bit on next fill
// RULE_08 - force dirty sets dirty bit on next fill
// RULE_09 - force tag still fills, using force bits as tag controls
// RULE_10 - software flushes by force tag, valid clear, sweeping addresses
// RULE_11 - ignore tag makes every probe a miss, victims dropped
// RULE_12 - long write holds data ram writes two cycles
// RULE_13 - no allocate stops cpu writes from filling lines
// RULE_14 - cache enable clear at reset stops all tag probes
// RULE_15 - memory width field mirrors the width input pin
// RULE_16 - arbitration 0x gives cpu priority, 10 gives dma priority
// RULE_17 - arbitration 11 gives strong dma priority
// RULE_18 - reserved bits read zero and ignore writes
`timescale 1ns/1ps
`default_nettype none
module l2_cache_general_control (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // board strap
  input  wire logic        wide_mem,
  // bus requesters
  input  wire logic        cpu_req,
  input  wire logic        dma_req,
  output logic             cpu_gnt,
  output logic             dma_gnt,
  // cache probe requests
  input  wire logic        probe_req,
  input  wire logic        probe_cpu_write,
  input  wire logic        data_wr_req,
  // tag ram read results
  input  wire logic        tag_match,
  input  wire logic        tag_par_ok,
  input  wire logic        tag_valid,
  input  wire logic        tag_dirty,
  // tag and data ram control
  output logic             probe_out,
  output logic             probe_miss,
  output logic             victim_wb,
  output logic             fill_we,
  output logic             fill_valid,
  output logic             fill_dirty,
  output logic             fill_par,
  output logic             fill_bad_addr_par,
  output logic             data_ram_we
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [15:0]        ctrl;
    logic               wide;
    logic [31:0]        rdata;
    logic               ready;
    logic               slverr;
    l2ctl_pkg::grant_t  grant;
    logic               dma_streak;
    logic               probe;
    logic               miss;
    logic               victim;
    logic               fill;
    logic               fvalid;
    logic               fdirty;
    logic               fpar;
    logic               fbad;
    logic               dwe;
    logic [15:0]        probes;
  } top_t;

  top_t t_q;
  top_t t_d;

  l2_cache_req_if rq ();

  l2_cache_seq u_seq (
    .clk     (clk),
    .reset_n (reset_n),
    .ctrl    (t_q.ctrl),
    .rq      (rq.seq)
  );

  assign rq.probe      = probe_req;
  assign rq.hit_tag    = tag_match;
  assign rq.tag_par_ok = tag_par_ok;
  assign rq.line_valid = tag_valid;
  assign rq.line_dirty = tag_dirty;
  assign rq.cpu_write  = probe_cpu_write;
  assign rq.data_wr    = data_wr_req;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic        access;
    logic [15:0] rd16;
    logic [1:0]  arb;
    access = psel && penable && !t_q.ready;
    rd16   = 16'h0000;
    arb    = t_q.ctrl[l2ctl_pkg::ARB_LO_BIT +: 2];
    t_d = t_q;
    t_d.ready  = 1'b0;
    t_d.slverr = 1'b0;
    t_d.wide   = wide_mem; // [RULE_15]
    // apb: one wait state, answer on the second access-phase edge
    if (access) begin
      t_d.ready = 1'b1;
      unique case (paddr)
        l2ctl_pkg::GEN_CTRL_OFFSET: begin // [RULE_01]
          if (pwrite) begin
            // upper bits and reserved bits dropped on write
            t_d.ctrl = pwdata[15:0] & l2ctl_pkg::GEN_CTRL_WMASK; // [RULE_04] [RULE_18]
          end
          rd16 = t_q.ctrl;
          rd16[l2ctl_pkg::WIDE_BIT] = t_q.wide; // [RULE_15]
        end
        l2ctl_pkg::CACHE_STAT_OFFSET: begin // [RULE_01]
          // read only; writes simply ignored
          rd16 = t_q.probes;
        end
        default: begin
          t_d.slverr = 1'b1;
        end
      endcase
      // reads leave all state untouched
      t_d.rdata = {16'h0000, rd16}; // [RULE_02] [RULE_04]
    end
    // arbitration: grant one requester per cycle
    t_d.grant = l2ctl_pkg::GRANT_NONE;
    if (cpu_req && dma_req) begin
      unique case (arb)
        l2ctl_pkg::ARB_DMA: begin
          t_d.grant = l2ctl_pkg::GRANT_DMA; // [RULE_16]
        end
        l2ctl_pkg::ARB_DMA_STRONG: begin
          // cpu only gets one slot after two dma grants in a row
          t_d.grant = (t_q.dma_streak && t_q.grant == l2ctl_pkg::GRANT_DMA)
                      ? l2ctl_pkg::GRANT_CPU : l2ctl_pkg::GRANT_DMA; // [RULE_17]
        end
        default: begin
          t_d.grant = l2ctl_pkg::GRANT_CPU; // [RULE_16]
        end
      endcase
    end else if (dma_req) begin
      t_d.grant = l2ctl_pkg::GRANT_DMA;
    end else if (cpu_req) begin
      t_d.grant = l2ctl_pkg::GRANT_CPU;
    end
    t_d.dma_streak = (t_d.grant == l2ctl_pkg::GRANT_DMA) && (t_q.grant == l2ctl_pkg::GRANT_DMA);
    // sequencer results registered to keep outputs on flops
    t_d.probe  = rq.probe_q;
    t_d.miss   = rq.miss;
    t_d.victim = rq.victim_wb;
    t_d.fill   = rq.fill;
    t_d.fvalid = rq.fill_valid;
    t_d.fdirty = rq.fill_dirty;
    t_d.fpar   = rq.fill_par;
    t_d.fbad   = rq.fill_bad_ap;
    t_d.dwe    = rq.data_we;
    if (rq.probe_q) begin
      t_d.probes = t_q.probes + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      t_q       <= '0;
      t_q.ctrl  <= l2ctl_pkg::GEN_CTRL_RESET; // [RULE_14] [RULE_16]
      t_q.grant <= l2ctl_pkg::GRANT_NONE;
    end else begin
      t_q <= t_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign prdata            = t_q.rdata;
  assign pready            = t_q.ready;
  assign pslverr           = t_q.slverr;
  assign cpu_gnt           = t_q.grant == l2ctl_pkg::GRANT_CPU;
  assign dma_gnt           = t_q.grant == l2ctl_pkg::GRANT_DMA;
  assign probe_out         = t_q.probe;
  assign probe_miss        = t_q.miss;
  assign victim_wb         = t_q.victim;
  assign fill_we           = t_q.fill;
  assign fill_valid        = t_q.fvalid;
  assign fill_dirty        = t_q.fdirty;
  assign fill_par          = t_q.fpar;
  assign fill_bad_addr_par = t_q.fbad;
  assign data_ram_we       = t_q.dwe;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  rd_no_effect_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_02]
    psel && penable && !pwrite |=> t_q.ctrl == $past(t_q.ctrl))
    else $error("read altered control register");
  upper_zero_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_04]
    pready |-> prdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  reserved_zero_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_18]
    (t_q.ctrl & ~l2ctl_pkg::GEN_CTRL_WMASK) == 16'h0000)
    else $error("reserved control bit set");
  wide_read_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_15]
    psel && penable && !pready && !pwrite && paddr == l2ctl_pkg::GEN_CTRL_OFFSET
    |=> prdata[l2ctl_pkg::WIDE_BIT] == $past(t_q.wide))
    else $error("memory width bit wrong");
  cpu_prio_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_16]
    cpu_req && dma_req && !t_q.ctrl[2] |=> cpu_gnt)
    else $error("cpu priority not honoured");
  dma_prio_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_16]
    cpu_req && dma_req && t_q.ctrl[2:1] == l2ctl_pkg::ARB_DMA |=> dma_gnt)
    else $error("dma priority not honoured");
  strong_dma_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_17]
    cpu_req && dma_req && t_q.ctrl[2:1] == l2ctl_pkg::ARB_DMA_STRONG && !dma_gnt
    |=> dma_gnt)
    else $error("strong dma priority lost");
  ready_len_a: assert property (@(posedge clk) disable iff (!reset_n)
    pready |=> !pready)
    else $error("pready longer than one cycle");
  gen_wr_cov: cover property (@(posedge clk) disable iff (!reset_n)
    pready && pwrite && paddr == l2ctl_pkg::GEN_CTRL_OFFSET);
  dma_cov: cover property (@(posedge clk) disable iff (!reset_n) cpu_req && dma_gnt);

endmodule
`default_nettype wire

/* bench/bus_requester_model.sv */
/*
  bus_requester_model: processor and dma requesters on the system bus.
  Assumes: grants are registered levels; a request is held until granted.
*/
`timescale 1ns/1ps
`default_nettype none
module bus_requester_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // bench wishes
  input  wire logic cpu_want,
  input  wire logic dma_want,
  // arbiter side
  input  wire logic cpu_gnt,
  input  wire logic dma_gnt,
  output logic      cpu_req,
  output logic      dma_req
);
  // ----------------------------------------------------------------------
  // request hold
  // ----------------------------------------------------------------------
  // a dropped wish still waits for its grant, as a real requester would
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_req <= 1'b0;
      dma_req <= 1'b0;
    end else begin
      cpu_req <= cpu_want | (cpu_req & !cpu_gnt);
      dma_req <= dma_want | (dma_req & !dma_gnt);
    end
  end
endmodule
`default_nettype wire

/* bench/tb.sv */
/*
  tb: self-checking bench for the l2 cache general control block.
  Assumes: apb answer whenever pready rises, probe results two edges later.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk, reset_n, psel, penable, pwrite, wide_mem, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic        cpu_want, dma_want, cpu_req, dma_req, cpu_gnt, dma_gnt;
  logic        probe_req, probe_cpu_write, data_wr_req;
  logic        tag_match, tag_par_ok, tag_valid, tag_dirty;
  logic        probe_out, probe_miss, victim_wb, fill_we, fill_valid, fill_dirty;
  logic        fill_par, fill_bad_addr_par, data_ram_we, win, win_q;
  logic [32:0] rd_q[$];
  logic [13:0] pr_q[$];
  logic [1:0]  wr_q[$];
  logic [7:0]  arb_q[$];
  logic [32:0] re;
  logic [13:0] pe;
  logic [15:0] ctl, c;
  int          fails, checked, run, n_cpu, n_dma, probes;

  localparam logic [11:0] GEN  = l2ctl_pkg::GEN_CTRL_OFFSET;
  localparam logic [11:0] STAT = l2ctl_pkg::CACHE_STAT_OFFSET;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  l2_cache_general_control dut (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wide_mem(wide_mem), .cpu_req(cpu_req), .dma_req(dma_req), .cpu_gnt(cpu_gnt),
    .dma_gnt(dma_gnt), .probe_req(probe_req), .probe_cpu_write(probe_cpu_write),
    .data_wr_req(data_wr_req), .tag_match(tag_match), .tag_par_ok(tag_par_ok),
    .tag_valid(tag_valid), .tag_dirty(tag_dirty), .probe_out(probe_out),
    .probe_miss(probe_miss), .victim_wb(victim_wb), .fill_we(fill_we),
    .fill_valid(fill_valid), .fill_dirty(fill_dirty), .fill_par(fill_par),
    .fill_bad_addr_par(fill_bad_addr_par), .data_ram_we(data_ram_we));

  bus_requester_model requesters (
    .clk(clk), .reset_n(reset_n), .cpu_want(cpu_want), .dma_want(dma_want),
    .cpu_gnt(cpu_gnt), .dma_gnt(dma_gnt), .cpu_req(cpu_req), .dma_req(dma_req));

  // ----------------------------------------------------------------------
  // compare and close
  // ----------------------------------------------------------------------
  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] seen);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run;
    // results still owed count as misses
    if (rd_q.size() + pr_q.size() + wr_q.size() + arb_q.size() != 0) fails++;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no wait count assumed; the watchdog ends a hung access
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask

  task automatic set_ctl(input logic [15:0] v);
    ctl = v & l2ctl_pkg::GEN_CTRL_WMASK;
    xfer(1'b1, GEN, {16'h0, ctl});
  endtask

  task automatic probe(input logic m, input logic v, input logic d, input logic w,
                       input logic p);
    logic       miss, fw, ft;
    logic [6:0] val, msk;
    ft = ctl[9];
    miss = ctl[8] | !(m & v & p);
    fw = miss & !(w & ctl[6]);
    val = {miss, miss & !ctl[8] & v & d, fw, ft ? ctl[11] : 1'b1,
           ft ? ctl[10] : (w | ctl[10]), ft ? ctl[12] : 1'b1, ctl[13]};
    // parity of a plain fill is left open
    msk = {3'h7, 1'b1, fw, fw, fw & (ft | ctl[12]), 1'b1};
    if (ctl[5]) begin
      pr_q.push_back({msk, val});
      probes++;
    end
    probe_req <= 1'b1;
    tag_match <= m;
    tag_valid <= v;
    tag_dirty <= d;
    probe_cpu_write <= w;
    tag_par_ok <= p;
    @(posedge clk);
    probe_req <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic dwrite;
    // a disabled cache writes nothing, so nothing is owed
    if (ctl[5]) wr_q.push_back(ctl[7] ? 2'h2 : 2'h1);
    data_wr_req <= 1'b1;
    @(posedge clk);
    data_wr_req <= 1'b0;
    repeat (5) @(posedge clk);
  endtask

  task automatic arb(input logic [1:0] mode, input logic [7:0] e);
    set_ctl({13'h0, mode, 1'b0});
    cpu_want <= 1'b1;
    dma_want <= 1'b1;
    repeat (4) @(posedge clk);
    arb_q.push_back(e);
    win <= 1'b1;
    repeat (12) @(posedge clk);
    win <= 1'b0;
    cpu_want <= 1'b0;
    dma_want <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // ----------------------------------------------------------------------
  // result monitor
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    win_q <= win;
    if (psel && penable && pready && !pwrite) begin
      re = rd_q.size() ? rd_q.pop_front() : 33'h1FFFFFFFF;
      cmp("prdata", re[31:0], prdata);
      cmp("pslverr", {31'h0, re[32]}, {31'h0, pslverr});
    end
    if (probe_out === 1'b1) begin
      pe = pr_q.size() ? pr_q.pop_front() : 14'h0;
      cmp("probe_out", {31'h0, pe[13]}, {31'h0, probe_out});
      cmp("fill", {25'h0, pe[6:0] & pe[13:7]},
          {25'h0, {probe_miss, victim_wb, fill_we, fill_valid, fill_dirty, fill_par,
                   fill_bad_addr_par} & pe[13:7]});
    end
    if (data_ram_we === 1'b1) run++;
    else if (run > 0) begin
      cmp("data_ram_we", wr_q.size() ? 32'(wr_q.pop_front()) : 32'h0, 32'(run));
      run = 0;
    end
    if (win) begin
      n_cpu += int'(cpu_gnt);
      n_dma += int'(dma_gnt);
    end else if (win_q) begin
      cmp("grants", {24'h0, arb_q.size() ? arb_q.pop_front() : 8'h0},
          {24'h0, 4'(n_cpu), 4'(n_dma)});
      n_cpu = 0;
      n_dma = 0;
    end
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, probe_req, probe_cpu_write, data_wr_req} = 6'h00;
    {tag_match, tag_par_ok, tag_valid, tag_dirty, cpu_want, dma_want} = 6'h00;
    {win, reset_n, wide_mem} = 3'h1;
    paddr = 12'h000;
    pwdata = 32'h0;
    ctl = 16'h0000;
    {fails, checked, run, n_cpu, n_dma, probes} = {6{32'h0}};
    void'($urandom(8));
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(GEN, 33'h000000010);
    rd(STAT, 33'h0);
    wide_mem <= 1'b0;
    @(posedge clk);
    rd(GEN, 33'h0);
    xfer(1'b1, GEN, 32'hFFFFFFFF);
    rd(GEN, 33'h000003FE6);
    rd(12'h010, 33'h100000000);
    set_ctl(16'h0000);
    repeat (3) probe(1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
    wide_mem <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      c = (i == 0) ? 16'h0220 : 16'($urandom());
      c[5] = (i % 5 != 4);
      set_ctl(c);
      rd(GEN, {17'h0, ctl | 16'h0010});
      r = $urandom();
      probe(r[0], r[1], r[2], r[3], ctl[8] ? r[4] : 1'b1);
      dwrite();
    end
    rd(STAT, {17'h0, 16'(probes)});
    xfer(1'b1, STAT, 32'h0000FFFF);
    rd(STAT, {17'h0, 16'(probes)});
    arb(2'h0, 8'hC0);
    arb(2'h1, 8'hC0);
    arb(2'h2, 8'h0C);
    arb(2'h3, 8'h48);
    complete_run();
  end

  // ----------------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------------
  initial begin
    #(500000);
    fails++;
    complete_run();
  end
endmodule
`default_nettype wire
